// file: iss_pkg.sv
package iss_pkg;
  // Datapath widths
  localparam int NCH_DEF = 4;
  localparam int VAL_W = 20;
  localparam int RAW_W = 16;
  localparam int PRM_W = 16;
  localparam int TYPE_W = 5;
  localparam int DP_W = 2;

  // Global register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CJC = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  // Channel block: region index addr[11:6], region 0 is global
  localparam int CH_SHIFT = 6;
  localparam int REG_SHIFT = 2;

  // Word index inside a channel block
  localparam logic [3:0] F_TYPE = 4'h0;
  localparam logic [3:0] F_UNIT = 4'h1;
  localparam logic [3:0] F_SHI = 4'h2;
  localparam logic [3:0] F_SLO = 4'h3;
  localparam logic [3:0] F_DP = 4'h4;
  localparam logic [3:0] F_PT1 = 4'h5;
  localparam logic [3:0] F_PT2 = 4'h6;
  localparam logic [3:0] F_SH1 = 4'h7;
  localparam logic [3:0] F_SH2 = 4'h8;

  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CJC_INT_BIT = 0;
  localparam int UNIT_F_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CH_LSB = 8;

  // Reset values
  localparam logic [TYPE_W-1:0] TYPE_RST = 5'h05;
  localparam logic UNIT_RST = 1'b0;
  localparam logic CJC_RST = 1'b1;
  localparam logic [PRM_W-1:0] SHI_RST = 16'h03e8;
  localparam logic [PRM_W-1:0] SLO_RST = 16'h0000;
  localparam logic [DP_W-1:0] DP_RST = 2'h1;
  localparam logic [PRM_W-1:0] PT1_RST = 16'h0000;
  localparam logic [PRM_W-1:0] PT2_RST = 16'h03e8;
  localparam logic [PRM_W-1:0] SH_RST = 16'h0000;

  // Stored parameter limits, in counts of the least digit
  localparam logic signed [PRM_W-1:0] LIM_MIN = 16'hf831;
  localparam logic signed [PRM_W-1:0] LIM_MAX = 16'h270f;

  // Input type codes
  localparam logic [TYPE_W-1:0] TYPE_TC_FIRST = 5'h05;
  localparam logic [TYPE_W-1:0] TYPE_IR_LAST = 5'h18;
  localparam logic [TYPE_W-1:0] TYPE_AN_FIRST = 5'h19;
  localparam logic [TYPE_W-1:0] TYPE_AN_LAST = 5'h1d;
  localparam logic [TYPE_W-1:0] TYPE_TC_HI = 5'h1e;

  // Temperature path: tenths of a degree, fixed one fractional digit
  localparam logic [DP_W-1:0] TEMP_DP = 2'h1;
  localparam logic [DP_W-1:0] DP_NONE = 2'h0;
  localparam logic signed [VAL_W+3:0] F_MUL = 24'h000009;
  localparam logic signed [VAL_W+3:0] F_DIV = 24'h000005;
  localparam logic signed [VAL_W+3:0] F_OFF = 24'h000140;
  localparam logic signed [VAL_W-1:0] DEC_DIV = 20'h0000a;

  typedef enum {ST_IDLE, ST_REQ, ST_WAIT} iss_state_e;
  typedef enum {EN_IDLE, EN_DIV} iss_eng_e;
endpackage

// file: iss_corr_if.sv
`timescale 1ns/10ps
interface iss_corr_if #(parameter int W = 20);
  logic req_valid;
  logic req_ready;
  logic signed [W-1:0] x;
  logic signed [W-1:0] p1;
  logic signed [W-1:0] p2;
  logic signed [W-1:0] s1;
  logic signed [W-1:0] s2;
  logic res_valid;
  logic signed [W-1:0] res;

  modport master (output req_valid, x, p1, p2, s1, s2, input req_ready, res_valid, res);
  modport engine (input req_valid, x, p1, p2, s1, s2, output req_ready, res_valid, res);
endinterface

// file: iss_corr_engine.sv
`timescale 1ns/10ps
module iss_corr_engine
  import iss_pkg::*;
#(
  parameter int W = VAL_W
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  iss_corr_if.engine cif
);
  localparam int DW = W + 1;
  localparam int NW = 2 * DW;
  localparam int CW = $clog2(NW + 1);
  localparam logic [CW-1:0] LAST = CW'(NW - 1);

  iss_eng_e state_q;
  logic signed [DW-1:0] base_q;
  logic neg_q;
  logic [DW-1:0] den_q;
  logic [NW-1:0] num_q;
  logic [NW-1:0] quo_q;
  logic [DW:0] rem_q;
  logic [CW-1:0] cnt_q;
  logic res_valid_q;
  logic signed [W-1:0] res_q;

  // Differences and the slope product, taken straight from the request
  logic signed [DW-1:0] dx, ds, dpt, base_d;
  logic signed [NW-1:0] prod;
  logic [NW-1:0] prod_mag;
  logic [DW-1:0] den_mag;
  logic flat;
  assign dx = DW'(cif.x) - DW'(cif.p1);
  assign ds = DW'(cif.s2) - DW'(cif.s1);
  assign dpt = DW'(cif.p2) - DW'(cif.p1);
  assign base_d = DW'(cif.x) + DW'(cif.s1);
  assign prod = NW'(ds) * NW'(dx);
  assign prod_mag = prod[NW-1] ? NW'(-prod) : prod;
  assign den_mag = dpt[DW-1] ? DW'(-dpt) : dpt;
  // Equal points give no slope; fall back to the plain offset
  assign flat = (cif.s1 == cif.s2) || (cif.p1 == cif.p2);

  // One restoring division step per cycle
  logic [DW:0] rem_sh, rem_sub;
  logic fits;
  logic signed [NW-1:0] q_signed;
  logic signed [NW-1:0] sum_wide;
  assign rem_sh = {rem_q[DW-1:0], num_q[NW-1]};
  assign rem_sub = rem_sh - {1'b0, den_q};
  assign fits = (rem_sh >= {1'b0, den_q});
  assign q_signed = neg_q ? NW'(-{quo_q[NW-2:0], fits}) : {quo_q[NW-2:0], fits};
  assign sum_wide = NW'(base_q) + q_signed;

  assign cif.req_ready = (state_q == EN_IDLE);
  assign cif.res_valid = res_valid_q;
  assign cif.res = res_q;

  // Sequencer and divider registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= EN_IDLE;
      base_q <= '0;
      neg_q <= 1'b0;
      den_q <= '0;
      num_q <= '0;
      quo_q <= '0;
      rem_q <= '0;
      cnt_q <= '0;
      res_valid_q <= 1'b0;
      res_q <= '0;
    end else if (ce) begin
      res_valid_q <= 1'b0;
      case (state_q)
        EN_IDLE: begin
          if (cif.req_valid) begin
            if (flat) begin
              res_q <= W'(base_d);
              res_valid_q <= 1'b1;
            end else begin
              base_q <= base_d;
              neg_q <= prod[NW-1] ^ dpt[DW-1];
              num_q <= prod_mag;
              den_q <= den_mag;
              rem_q <= '0;
              quo_q <= '0;
              cnt_q <= '0;
              state_q <= EN_DIV;
            end
          end
        end
        EN_DIV: begin
          rem_q <= fits ? rem_sub : rem_sh;
          quo_q <= {quo_q[NW-2:0], fits};
          num_q <= {num_q[NW-2:0], 1'b0};
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == LAST) begin
            // Same line beyond both points, truncated toward zero
            res_q <= W'(sum_wide);
            res_valid_q <= 1'b1;
            state_q <= EN_IDLE;
          end
        end
        default: state_q <= EN_IDLE;
      endcase
    end
  end
endmodule

// file: iss_top.sv
//
// Function
// - Per-channel unit: 0 Celsius, 1 Fahrenheit
// - Unit only affects temperature input types
// - Setup fields locked while operation runs
// - Common junction mode: 0 external, 1 internal
// - Junction mode only for thermocouple, infrared
// - Scaling and decimal point analog only
// - Map analog range onto lower/upper limits
// - Decimal point field 0..3, default 1
// - Larger limit acts as upper limit
// - Two points and two shifts per channel
// - Shifts follow decimals, none means one
// - Equal shifts add constant offset everywhere
// - Unequal shifts give two-point linear correction
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
module iss_top
  import iss_pkg::*;
#(
  parameter int NCH = NCH_DEF,
  parameter int CH_W = (NCH > 1) ? $clog2(NCH) : 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic samp_valid,
  output logic samp_ready,
  input wire logic [CH_W-1:0] samp_ch,
  input wire logic [RAW_W-1:0] samp_raw,
  output logic pv_valid,
  output logic [CH_W-1:0] pv_ch,
  output logic signed [VAL_W-1:0] pv_value,
  output logic [DP_W-1:0] pv_dp,
  output logic pv_cjc_apply,
  output logic cjc_internal
);
  // Stored settings, one entry per channel; run flag and junction mode are common
  logic [TYPE_W-1:0] type_q [NCH];
  logic unit_q [NCH];
  logic [PRM_W-1:0] shi_q [NCH];
  logic [PRM_W-1:0] slo_q [NCH];
  logic [DP_W-1:0] dp_q [NCH];
  logic [PRM_W-1:0] pt1_q [NCH];
  logic [PRM_W-1:0] pt2_q [NCH];
  logic [PRM_W-1:0] sh1_q [NCH];
  logic [PRM_W-1:0] sh2_q [NCH];
  logic run_q;
  logic cjc_q;

  function automatic logic is_analog(input logic [TYPE_W-1:0] t);
    return (t >= TYPE_AN_FIRST) && (t <= TYPE_AN_LAST);
  endfunction

  function automatic logic is_cjc_type(input logic [TYPE_W-1:0] t);
    return ((t >= TYPE_TC_FIRST) && (t <= TYPE_IR_LAST)) || (t == TYPE_TC_HI);
  endfunction

  function automatic logic in_range(input logic [31:0] v);
    logic signed [PRM_W-1:0] s;
    s = $signed(v[PRM_W-1:0]);
    return (s >= LIM_MIN) && (s <= LIM_MAX);
  endfunction

  function automatic logic signed [VAL_W-1:0] ext(input logic [PRM_W-1:0] v);
    return {{(VAL_W-PRM_W){v[PRM_W-1]}}, v};
  endfunction

  function automatic logic [31:0] rd32(input logic [PRM_W-1:0] v);
    return {{(32-PRM_W){v[PRM_W-1]}}, v};
  endfunction

  // AHB-Lite address phase capture
  logic ahb_go;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  assign ahb_go = hsel && htrans[1] && hready;

  logic [5:0] a_reg;
  logic [3:0] a_fld;
  logic [5:0] w_reg;
  logic [3:0] w_fld;
  assign a_reg = haddr[11:CH_SHIFT];
  assign a_fld = haddr[CH_SHIFT-1:REG_SHIFT];
  assign w_reg = wr_addr_q[11:CH_SHIFT];
  assign w_fld = wr_addr_q[CH_SHIFT-1:REG_SHIFT];

  logic wr_glob;
  logic wr_locked;
  assign wr_glob = wr_pend_q && (w_reg == 6'h00);
  assign wr_locked = run_q;

  iss_state_e state_q;
  logic [CH_W-1:0] cur_ch_q;

  // Read mux, resolved in the address phase so data stand with zero wait
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h00000000;
    if (a_reg == 6'h00) begin
      case (haddr[11:0])
        OFF_CTRL: rd_d[CTRL_RUN_BIT] = run_q;
        OFF_CJC: rd_d[CJC_INT_BIT] = cjc_q;
        OFF_STAT: begin
          rd_d[STAT_BUSY_BIT] = (state_q != ST_IDLE);
          rd_d[STAT_CH_LSB +: CH_W] = cur_ch_q;
        end
        default: rd_d = 32'h00000000;
      endcase
    end else if (32'(a_reg) <= NCH) begin
      for (int c = 0; c < NCH; c++) begin
        if (32'(a_reg) == c + 1) begin
          case (a_fld)
            F_TYPE: rd_d = {{(32-TYPE_W){1'b0}}, type_q[c]};
            F_UNIT: rd_d[UNIT_F_BIT] = unit_q[c];
            F_SHI: rd_d = rd32(shi_q[c]);
            F_SLO: rd_d = rd32(slo_q[c]);
            F_DP: rd_d = {{(32-DP_W){1'b0}}, dp_q[c]};
            F_PT1: rd_d = rd32(pt1_q[c]);
            F_PT2: rd_d = rd32(pt2_q[c]);
            F_SH1: rd_d = rd32(sh1_q[c]);
            F_SH2: rd_d = rd32(sh2_q[c]);
            default: rd_d = 32'h00000000;
          endcase
        end
      end
    end
  end

  // Bus slave: never waits, always OKAY; unmapped reads give zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= ahb_go && hwrite;
      if (ahb_go) begin
        wr_addr_q <= haddr[11:0];
        if (!hwrite) begin
          hrdata <= rd_d;
        end
      end
    end
  end

  // Global control and the common junction mode
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= 1'b0;
      cjc_q <= CJC_RST;
    end else if (ce) begin
      if (wr_glob && (wr_addr_q == OFF_CTRL)) begin
        run_q <= hwdata[CTRL_RUN_BIT];
      end
      if (wr_glob && (wr_addr_q == OFF_CJC) && !wr_locked) begin
        cjc_q <= hwdata[CJC_INT_BIT];
      end
    end
  end

  // Channel settings; out-of-range values are dropped
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < NCH; c++) begin
        type_q[c] <= TYPE_RST;
        unit_q[c] <= UNIT_RST;
        shi_q[c] <= SHI_RST;
        slo_q[c] <= SLO_RST;
        dp_q[c] <= DP_RST;
        pt1_q[c] <= PT1_RST;
        pt2_q[c] <= PT2_RST;
        sh1_q[c] <= SH_RST;
        sh2_q[c] <= SH_RST;
      end
    end else if (ce) begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_pend_q && (32'(w_reg) == c + 1)) begin
          case (w_fld)
            F_TYPE: begin
              if (!wr_locked && (hwdata[TYPE_W-1:0] <= TYPE_TC_HI)) begin
                type_q[c] <= hwdata[TYPE_W-1:0];
              end
            end
            F_UNIT: if (!wr_locked) unit_q[c] <= hwdata[UNIT_F_BIT];
            F_SHI: if (!wr_locked && in_range(hwdata)) shi_q[c] <= hwdata[PRM_W-1:0];
            F_SLO: if (!wr_locked && in_range(hwdata)) slo_q[c] <= hwdata[PRM_W-1:0];
            F_DP: if (!wr_locked) dp_q[c] <= hwdata[DP_W-1:0];
            // Correction values may be tuned while running
            F_PT1: if (in_range(hwdata)) pt1_q[c] <= hwdata[PRM_W-1:0];
            F_PT2: if (in_range(hwdata)) pt2_q[c] <= hwdata[PRM_W-1:0];
            F_SH1: if (in_range(hwdata)) sh1_q[c] <= hwdata[PRM_W-1:0];
            F_SH2: if (in_range(hwdata)) sh2_q[c] <= hwdata[PRM_W-1:0];
            default: ;
          endcase
        end
      end
    end
  end

  // Sample conditioning for the channel being taken
  logic [TYPE_W-1:0] s_type;
  logic s_an;
  logic [DP_W-1:0] s_dp;
  assign s_type = type_q[samp_ch];
  assign s_an = is_analog(s_type);
  assign s_dp = s_an ? dp_q[samp_ch] : TEMP_DP;

  // Temperature: raw in tenths of a degree Celsius
  logic signed [VAL_W-1:0] c_val;
  logic signed [VAL_W+3:0] f_wide;
  logic signed [VAL_W-1:0] t_val;
  assign c_val = {{(VAL_W-RAW_W){samp_raw[RAW_W-1]}}, samp_raw};
  assign f_wide = ((VAL_W+4)'(c_val) * F_MUL) / F_DIV + F_OFF;
  assign t_val = unit_q[samp_ch] ? VAL_W'(f_wide) : c_val;

  // Analog: raw is an unsigned fraction of the input span
  logic signed [VAL_W-1:0] hi_v, lo_v, eff_hi, eff_lo;
  logic [PRM_W-1:0] span;
  logic [PRM_W+RAW_W-1:0] span_prod;
  logic signed [VAL_W-1:0] a_val;
  assign hi_v = ext(shi_q[samp_ch]);
  assign lo_v = ext(slo_q[samp_ch]);
  assign eff_hi = (lo_v > hi_v) ? lo_v : hi_v;
  assign eff_lo = (lo_v > hi_v) ? hi_v : lo_v;
  assign span = PRM_W'(eff_hi - eff_lo);
  assign span_prod = (PRM_W+RAW_W)'(span) * (PRM_W+RAW_W)'(samp_raw);
  // Truncating the fraction keeps the full-scale code just below the limit
  assign a_val = eff_lo + VAL_W'(span_prod[PRM_W+RAW_W-1:RAW_W]);

  // Shifts are in tenths when no decimal digit is shown
  logic dec_fix;
  logic signed [VAL_W-1:0] s1_v, s2_v;
  assign dec_fix = s_an && (s_dp == DP_NONE);
  assign s1_v = dec_fix ? ext(sh1_q[samp_ch]) / DEC_DIV : ext(sh1_q[samp_ch]);
  assign s2_v = dec_fix ? ext(sh2_q[samp_ch]) / DEC_DIV : ext(sh2_q[samp_ch]);

  iss_corr_if #(.W(VAL_W)) cif ();

  logic req_valid_q;
  logic signed [VAL_W-1:0] x_q, p1_q, p2_q, s1_q, s2_q;
  logic [DP_W-1:0] dp_hold_q;
  logic cjc_hold_q;
  assign cif.req_valid = req_valid_q;
  assign cif.x = x_q;
  assign cif.p1 = p1_q;
  assign cif.p2 = p2_q;
  assign cif.s1 = s1_q;
  assign cif.s2 = s2_q;

  iss_corr_engine #(.W(VAL_W)) u_corr (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .cif(cif)
  );

  // Sample sequencer: one sample in flight, ready drops while busy
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      samp_ready <= 1'b0;
      req_valid_q <= 1'b0;
      cur_ch_q <= '0;
      x_q <= '0;
      p1_q <= '0;
      p2_q <= '0;
      s1_q <= '0;
      s2_q <= '0;
      dp_hold_q <= DP_RST;
      cjc_hold_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          samp_ready <= 1'b1;
          if (samp_valid && samp_ready) begin
            samp_ready <= 1'b0;
            cur_ch_q <= samp_ch;
            x_q <= s_an ? a_val : t_val;
            p1_q <= ext(pt1_q[samp_ch]);
            p2_q <= ext(pt2_q[samp_ch]);
            s1_q <= s1_v;
            s2_q <= s2_v;
            dp_hold_q <= s_dp;
            cjc_hold_q <= is_cjc_type(s_type);
            req_valid_q <= 1'b1;
            state_q <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (cif.req_ready) begin
            req_valid_q <= 1'b0;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cif.res_valid) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Result outputs; pv_valid is a one-cycle pulse
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pv_valid <= 1'b0;
      pv_ch <= '0;
      pv_value <= '0;
      pv_dp <= DP_RST;
      pv_cjc_apply <= 1'b0;
      cjc_internal <= CJC_RST;
    end else if (ce) begin
      pv_valid <= 1'b0;
      cjc_internal <= cjc_q;
      if ((state_q == ST_WAIT) && cif.res_valid) begin
        pv_valid <= 1'b1;
        pv_ch <= cur_ch_q;
        pv_value <= cif.res;
        pv_dp <= dp_hold_q;
        pv_cjc_apply <= cjc_hold_q;
      end
    end
  end
endmodule

// file: iss_sva.sv
`timescale 1ns/10ps
module iss_sva
  import iss_pkg::*;
#(
  parameter int NCH = NCH_DEF,
  parameter int CH_W = 2
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic samp_valid,
  input wire logic samp_ready,
  input wire logic pv_valid,
  input wire logic [CH_W-1:0] pv_ch,
  input wire logic signed [VAL_W-1:0] pv_value,
  input wire logic [DP_W-1:0] pv_dp,
  input wire logic pv_cjc_apply
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // A taken sample, then a quiet gap, then one result within the divider span
  sequence take_s;
    samp_valid && samp_ready && ce;
  endsequence
  sequence answer_s;
    (!pv_valid && !samp_ready) [*2] ##[1:43] pv_valid;
  endsequence
  ans_window_a: assert property (take_s |=> answer_s)
    else $error("result not in its window");
  pv_pulse_a: assert property (pv_valid |=> !pv_valid)
    else $error("result strobe longer than one cycle");
  // The sequencer reopens the sample port on the edge after the result strobe
  ready_back_a: assert property (pv_valid && ce |=> samp_ready)
    else $error("sample port not free with result");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("refused access not silent");
  rdata_src_a: assert property ($changed(hrdata) |-> $past(hsel && htrans[1] && hready && !hwrite && ce))
    else $error("read data moved without a read");
  temp_dp_a: assert property (pv_valid && pv_cjc_apply |-> pv_dp == TEMP_DP)
    else $error("temperature result not at one digit");
  pv_hold_a: assert property (!pv_valid |-> $stable(pv_ch) && $stable(pv_value))
    else $error("result moved without strobe");
  ce_freeze_a: assert property (!ce |=> $stable(samp_ready) && $stable(pv_value))
    else $error("state moved while clock enable low");
endmodule

bind iss_top iss_sva #(.NCH(NCH), .CH_W(CH_W)) u_sva (.core_clk(core_clk), .resetn(resetn),
  .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .samp_valid(samp_valid),
  .samp_ready(samp_ready), .pv_valid(pv_valid), .pv_ch(pv_ch), .pv_value(pv_value),
  .pv_dp(pv_dp), .pv_cjc_apply(pv_cjc_apply));

// file: iss_sensor_model.sv
`timescale 1ns/10ps
// Sensor side: offers one reading per go pulse and holds it until taken
module iss_sensor_model
  import iss_pkg::*;
(
  input wire logic core_clk,
  input wire logic go,
  input wire logic [1:0] ch_in,
  input wire logic [RAW_W-1:0] raw_in,
  input wire logic samp_ready,
  output logic samp_valid = 1'b0,
  output logic [1:0] samp_ch = 2'h0,
  output logic [RAW_W-1:0] samp_raw = 16'h0
);
  // Once taken the lines show inverted data, so a late read cannot match
  always @(posedge core_clk) begin
    if (samp_valid && samp_ready) begin
      samp_valid <= 1'b0;
      samp_ch <= ~samp_ch;
      samp_raw <= ~samp_raw;
    end else if (go) begin
      samp_valid <= 1'b1;
      samp_ch <= ch_in;
      samp_raw <= raw_in;
    end
  end
endmodule

// file: test_input_scaling_and_shift.sv
`timescale 1ns/10ps
module test_input_scaling_and_shift
  import iss_pkg::*;
();
  logic core_clk = 1'b0, resetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic [1:0] htrans = 2'h0, m_ch = 2'h0, samp_ch, pv_ch;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [RAW_W-1:0] m_raw = 16'h0, samp_raw;
  logic hreadyout, hresp, samp_valid, samp_ready, pv_valid, pv_cjc_apply, cjc_internal;
  logic signed [VAL_W-1:0] pv_value;
  logic [DP_W-1:0] pv_dp;
  logic rd_ph = 1'b0;
  logic [31:0] rd_q[$], pv_q[$];
  int err_total = 0, checked = 0, sh[4][9], r;

  iss_top #(.NCH(4)) DUT (.core_clk(core_clk), .resetn(resetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .samp_valid(samp_valid), .samp_ready(samp_ready), .samp_ch(samp_ch),
    .samp_raw(samp_raw), .pv_valid(pv_valid), .pv_ch(pv_ch), .pv_value(pv_value),
    .pv_dp(pv_dp), .pv_cjc_apply(pv_cjc_apply), .cjc_internal(cjc_internal));
  iss_sensor_model u_sens (.core_clk(core_clk), .go(go), .ch_in(m_ch), .raw_in(m_raw),
    .samp_ready(samp_ready), .samp_valid(samp_valid), .samp_ch(samp_ch),
    .samp_raw(samp_raw));

  initial forever #2.5 core_clk = ~core_clk;

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_pv(input logic [31:0] e, input logic [31:0] g);
    cmp(e, g);
  endtask
  task automatic print_verdict();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Single transfer: hold each phase until hready is seen high
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, input int e);
    rd_q.push_back(32'(e));
    ahb(1'b0, a, $urandom);
  endtask
  function automatic logic [31:0] ra(input int c, input int f);
    return 32'(((c + 1) << CH_SHIFT) | (f << REG_SHIFT));
  endfunction
  function automatic int pick(input int f, input int s1);
    case (f)
      0: return $urandom_range(0, 30);
      1: return $urandom_range(0, 1);
      4: return $urandom_range(0, 3);
      7: return $urandom_range(0, 1999) - 999;
      8: return s1 + 10 * ($urandom_range(0, 4) - 2);
      default: return $urandom_range(0, 11998) - 1999;
    endcase
  endfunction
  // Reference value: unit, scaling, shift and two-point line
  function automatic logic [31:0] expect_pv(input int c, input int r);
    int t, lo, hi, x, s1, s2, dp, p1, p2;
    logic [19:0] v;
    t = sh[c][0];
    p1 = sh[c][5];
    p2 = sh[c][6];
    lo = sh[c][3] < sh[c][2] ? sh[c][3] : sh[c][2];
    hi = sh[c][3] < sh[c][2] ? sh[c][2] : sh[c][3];
    dp = (t >= 25 && t <= 29) ? sh[c][4] : 1;
    s1 = (dp == 0) ? sh[c][7] / 10 : sh[c][7];
    s2 = (dp == 0) ? sh[c][8] / 10 : sh[c][8];
    if (t >= 25 && t <= 29) x = lo + (((hi - lo) * r) >>> 16);
    else x = (sh[c][1] == 1) ? (r * 9) / 5 + 320 : r;
    v = 20'(x + s1);
    if (s1 != s2 && p1 != p2) v = 20'(x + s1 + (s2 - s1) * (x - p1) / (p2 - p1));
    return {7'h0, (t >= 5 && t <= 24) || t == 30, 2'(dp), 2'(c), v};
  endfunction

  // Result watcher: each read data phase or result strobe takes the oldest note
  always @(posedge core_clk) begin
    if (rd_ph && hreadyout === 1'b1) cmp(rd_q.pop_front(), hrdata);
    if (hreadyout === 1'b1) rd_ph = hsel && htrans[1] && !hwrite;
    if (pv_valid === 1'b1) begin
      cmp_pv(pv_q.pop_front(), {7'h0, pv_cjc_apply, pv_dp, pv_ch, pv_value});
    end
  end

  // Hang guard, well beyond the few thousand cycles the tests need
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h5af15c76));
    for (int c = 0; c < 4; c++) sh[c] = '{5, 0, 1000, 0, 1, 0, 1000, 0, 0};
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    for (int c = 0; c < 4; c++) for (int f = 0; f < 9; f++) rd(ra(c, f), sh[c][f]);
    rd(32'(OFF_CJC), 1);
    rd(32'hffc, 0);
    cmp(32'h00000001, cjc_internal);
    $display("test reset_values done");
    repeat (3) begin
      ahb(1'b1, 32'(OFF_CTRL), 32'h0);
      // Fresh settings per channel; the shifts differ by whole tens or not at all
      for (int c = 0; c < 4; c++) for (int f = 0; f < 9; f++) begin
        sh[c][f] = pick(f, sh[c][7]);
        ahb(1'b1, ra(c, f), 32'(sh[c][f]));
      end
      ahb(1'b1, 32'(OFF_CJC), 32'h0);
      repeat (2) @(posedge core_clk);
      cmp(32'h00000000, cjc_internal);
      ahb(1'b1, 32'(OFF_CTRL), 32'h1);
      // While running, setup writes and out-of-range values must bounce
      ahb(1'b1, 32'(OFF_CJC), 32'h1);
      rd(32'(OFF_CJC), 0);
      for (int f = 0; f < 5; f++) ahb(1'b1, ra(1, f), 32'(sh[1][f] ^ 1));
      ahb(1'b1, ra(1, 7), 32'h2710);
      for (int f = 0; f < 8; f++) rd(ra(1, f), sh[1][f]);
      // Back-to-back samples on random channels with random gaps
      repeat (8) begin
        int c;
        c = $urandom_range(0, 3);
        if (sh[c][0] >= 25 && sh[c][0] <= 29) r = $urandom_range(0, 65535);
        else r = $urandom_range(0, 4000) - 2000;
        pv_q.push_back(expect_pv(c, r));
        repeat ($urandom_range(0, 2)) @(posedge core_clk);
        @(posedge core_clk);
        go <= 1'b1;
        m_ch <= 2'(c);
        m_raw <= 16'(r);
        @(posedge core_clk);
        go <= 1'b0;
        do @(posedge core_clk); while (samp_valid !== 1'b0);
      end
      while (pv_q.size() != 0) @(posedge core_clk);
      $display("test scaling_shift_round done");
    end
    // Clock enable low must hold everything still
    @(posedge core_clk);
    ce <= 1'b0;
    repeat (3) @(posedge core_clk);
    ce <= 1'b1;
    rd(32'(OFF_CJC), 0);
    repeat (4) @(posedge core_clk);
    $display("test clock_enable done");
    print_verdict();
  end
endmodule
